// [common/msb_pkg.sv]
// Purpose: Constants, register map and carrier types of the system configuration register bank.
// Assumes: 40-bit physical addresses, four performance counters, eight variable ranges.
// Notes:   Unlisted offsets are local choices; the fixed-range register covers 8 x 64 KB.
package msb_pkg;

    // ------------------------------------------------------------
    // Register addresses
    // ------------------------------------------------------------
    localparam logic [31:0] ADDR_SYSTEM_CONFIGURATION = 32'hC001_0010;
    localparam logic [31:0] ADDR_FIX = 32'h4000_0000;
    localparam logic [31:0] ADDR_DEFTYPE = 32'h4000_0001;
    localparam logic [31:0] ADDR_TOPMEM = 32'h4000_0002;
    localparam logic [31:0] ADDR_TOPMEM2 = 32'h4000_0003;
    localparam logic [31:0] ADDR_LEG_TGT = 32'h4000_0008;
    localparam logic [31:0] ADDR_LONG_TGT = 32'h4000_0009;
    localparam logic [31:0] ADDR_CMP_TGT = 32'h4000_000A;
    localparam logic [31:0] ADDR_FMASK = 32'h4000_000B;
    localparam logic [31:0] ADDR_FS_BASE = 32'h4000_000C;
    localparam logic [31:0] ADDR_GS_BASE = 32'h4000_000D;
    localparam logic [31:0] ADDR_KGS_BASE = 32'h4000_000E;
    localparam logic [31:0] ADDR_FE_CS = 32'h4000_0010;
    localparam logic [31:0] ADDR_FE_SP = 32'h4000_0011;
    localparam logic [31:0] ADDR_FE_IP = 32'h4000_0012;
    localparam logic [31:0] ADDR_DBGCTL = 32'h4000_0018;
    localparam logic [31:0] ADDR_LB_SRC = 32'h4000_0019;
    localparam logic [31:0] ADDR_LB_DST = 32'h4000_001A;
    localparam logic [31:0] ADDR_LI_SRC = 32'h4000_001B;
    localparam logic [31:0] ADDR_LI_DST = 32'h4000_001C;
    localparam logic [31:0] ADDR_CYCLES = 32'h4000_0020;
    localparam logic [31:0] ADDR_VAR = 32'h4000_0030;
    localparam logic [31:0] ADDR_EVTSEL = 32'h4000_0040;
    localparam logic [31:0] ADDR_PERFCTR = 32'h4000_0048;

    // ------------------------------------------------------------
    // Fields, masks and reset values
    // ------------------------------------------------------------
    localparam int SC_FDE = 18;
    localparam int SC_FDM = 19;
    localparam int SC_VARIABLE_IO_ENABLE_BIT = 20;
    localparam int SC_TOM2EN = 21;
    localparam int SC_FWB = 22;
    localparam logic [31:0] SYSTEM_CONFIGURATION_RW_MASK = 32'h007C_0000;
    localparam logic [63:0] FIX_ATTR_MASK = 64'h1818_1818_1818_1818;
    localparam logic [63:0] DEF_TYPE_MASK = 64'h0000_0000_0000_0CFF;
    localparam int DEF_EN = 11;
    localparam int DEF_FIX_EN = 10;
    localparam int VAR_VALID = 11;
    localparam int EVT_EN = 22;
    localparam int EVT_EDGE = 18;
    localparam int DBG_REC = 0;
    localparam int VAR_N = 8;
    localparam int PERF_N = 4;
    localparam int PERF_W = 48;
    localparam int PA_W = 40;
    localparam logic [2:0] MT_UC = 3'h0;
    localparam logic [2:0] MT_WB = 3'h6;
    localparam logic [PA_W-1:0] FOUR_GB = 40'h01_0000_0000;
    localparam logic [PA_W-1:0] FIX_LIMIT = 40'h00_0008_0000;

    // ------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        OP_NONE = 3'b000,
        OP_REG_READ = 3'b001,
        OP_REG_WRITE = 3'b010,
        OP_CNT_READ = 3'b011,
        OP_CNT_READ_ORD = 3'b100,
        OP_PERF_READ = 3'b101,
        OP_BASE_SWAP = 3'b110
    } msb_op_type;

    typedef struct packed {
        logic valid;
        msb_op_type op;
        logic [1:0] cpl;
        logic [31:0] addr;
        logic [63:0] wdata;
    } msb_req_type;

    typedef struct packed {
        logic valid;
        logic fault;
        logic [63:0] data;
    } msb_rsp_type;

    typedef struct packed {
        logic long_active;
        logic mode64;
        logic counter_read_disable;
        logic perf_read_enable;
    } msb_mode_type;

    typedef struct packed {
        logic br_valid;
        logic [63:0] br_src;
        logic [63:0] br_dst;
        logic int_valid;
        logic [63:0] int_src;
        logic [63:0] int_dst;
    } msb_branch_type;

    typedef struct packed {
        logic [63:0] syscall_target;
        logic [63:0] syscall_flag_mask;
        logic [63:0] fs_base;
        logic [63:0] gs_base;
        logic fast_entry_allowed;
        logic [63:0] fast_entry_code_selector;
        logic [63:0] fast_entry_stack_pointer;
        logic [63:0] fast_entry_instr_pointer;
    } msb_link_type;

    typedef struct packed {
        logic [2:0] mem_type;
        logic read_to_dram_attr;
        logic write_to_dram_attr;
        logic is_dram;
        logic variable_range_io_enable;
    } msb_mem_type;

endpackage : msb_pkg

// [hw/msb_system_config_bank.sv]
// Purpose: Register bank for system configuration, linkage, memory typing, debug and counters.
// Assumes: One request per cycle; answer one cycle later; inputs synchronous to core_clk_in.
// Notes:   Memory type lookup is registered; page attribute override happens downstream.
`timescale 1ns/10ps
`default_nettype none

module msb_system_config_bank
    import msb_pkg::*;
(
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    input wire msb_req_type req_in,
    input wire msb_mode_type mode_in,
    input wire msb_branch_type branch_in,
    input wire logic [7:0] perf_events_in,
    input wire logic [PA_W-1:0] mem_addr_in,
    output msb_rsp_type rsp_out,
    output msb_link_type link_out,
    output msb_mem_type mem_out
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [31:0] system_configuration;
        logic [63:0] fix;
        logic [63:0] deftype;
        logic [63:0] topmem;
        logic [63:0] topmem2;
        logic [63:0] leg_tgt;
        logic [63:0] long_tgt;
        logic [63:0] cmp_tgt;
        logic [63:0] fmask;
        logic [63:0] fs_base;
        logic [63:0] gs_base;
        logic [63:0] kgs_base;
        logic [63:0] fe_cs;
        logic [63:0] fe_sp;
        logic [63:0] fe_ip;
        logic [63:0] dbgctl;
        logic [63:0] lb_src;
        logic [63:0] lb_dst;
        logic [63:0] li_src;
        logic [63:0] li_dst;
        logic [63:0] cycles;
        logic [VAR_N-1:0][63:0] vbase;
        logic [VAR_N-1:0][63:0] vmask;
        logic [PERF_N-1:0][31:0] evtsel;
        logic [PERF_N-1:0][PERF_W-1:0] perfctr;
        logic [7:0] ev_prev;
        msb_rsp_type rsp;
        msb_link_type link;
        msb_mem_type mem;
    } msb_state_type;

    msb_state_type s;
    msb_state_type next_s;

    logic [63:0] rd;
    logic hit;
    logic priv;
    logic ev;
    logic [2:0] vidx;
    logic [1:0] pidx;
    logic [7:0] fbyte;
    logic [PA_W-1:0] a;

    always_comb begin
        next_s = s;
        rd = 64'h0000_0000_0000_0000;
        hit = 1'b0;
        ev = 1'b0;
        fbyte = 8'h00;
        a = mem_addr_in;
        vidx = req_in.addr[3:1];
        pidx = req_in.addr[1:0];
        priv = (req_in.cpl == 2'b00);
        next_s.rsp.valid = 1'b0;
        next_s.rsp.fault = 1'b0;
        next_s.rsp.data = 64'h0000_0000_0000_0000;

        // ------------------------------------------------------------
        // Free-running cycle counter, enabled event counters and recording
        // ------------------------------------------------------------
        next_s.cycles = s.cycles + 64'h0000_0000_0000_0001;
        next_s.ev_prev = perf_events_in;
        for (int i = 0; i < PERF_N; i++) begin
            ev = perf_events_in[s.evtsel[i][2:0]];
            // Edge mode counts occurrences, level mode counts active cycles
            if (s.evtsel[i][EVT_EDGE]) begin
                ev = ev & ~s.ev_prev[s.evtsel[i][2:0]];
            end
            if (s.evtsel[i][EVT_EN] && ev) begin
                next_s.perfctr[i] = s.perfctr[i] + 48'h0000_0000_0001;
            end
        end
        if (s.dbgctl[DBG_REC]) begin
            if (branch_in.br_valid) begin
                next_s.lb_src = branch_in.br_src;
                next_s.lb_dst = branch_in.br_dst;
            end
            if (branch_in.int_valid) begin
                next_s.li_src = branch_in.int_src;
                next_s.li_dst = branch_in.int_dst;
            end
        end

        // ------------------------------------------------------------
        // Read decode
        // ------------------------------------------------------------
        hit = 1'b1;
        case (req_in.addr)
            ADDR_SYSTEM_CONFIGURATION: rd = {32'h0000_0000, s.system_configuration & SYSTEM_CONFIGURATION_RW_MASK};
            ADDR_FIX: rd = s.system_configuration[SC_FDM] ? s.fix : (s.fix & ~FIX_ATTR_MASK);
            ADDR_DEFTYPE: rd = s.deftype;
            ADDR_TOPMEM: rd = s.topmem;
            ADDR_TOPMEM2: rd = s.topmem2;
            ADDR_LEG_TGT: rd = s.leg_tgt;
            ADDR_LONG_TGT: rd = s.long_tgt;
            ADDR_CMP_TGT: rd = s.cmp_tgt;
            ADDR_FMASK: rd = s.fmask;
            ADDR_FS_BASE: rd = s.fs_base;
            ADDR_GS_BASE: rd = s.gs_base;
            ADDR_KGS_BASE: rd = s.kgs_base;
            ADDR_FE_CS: rd = s.fe_cs;
            ADDR_FE_SP: rd = s.fe_sp;
            ADDR_FE_IP: rd = s.fe_ip;
            ADDR_DBGCTL: rd = s.dbgctl;
            ADDR_LB_SRC: rd = s.lb_src;
            ADDR_LB_DST: rd = s.lb_dst;
            ADDR_LI_SRC: rd = s.li_src;
            ADDR_LI_DST: rd = s.li_dst;
            ADDR_CYCLES: rd = s.cycles;
            default: begin
                if (req_in.addr[31:4] == ADDR_VAR[31:4]) begin
                    rd = req_in.addr[0] ? s.vmask[vidx] : s.vbase[vidx];
                end else if (req_in.addr[31:3] == ADDR_EVTSEL[31:3] && !req_in.addr[2]) begin
                    rd = {32'h0000_0000, s.evtsel[pidx]};
                end else if (req_in.addr[31:3] == ADDR_PERFCTR[31:3] && !req_in.addr[2]) begin
                    rd = {16'h0000, s.perfctr[pidx]};
                end else begin
                    hit = 1'b0;
                end
            end
        endcase

        // ------------------------------------------------------------
        // Instruction handling
        // ------------------------------------------------------------
        if (req_in.valid) begin
            next_s.rsp.valid = 1'b1;
            unique case (req_in.op)
                OP_NONE: begin
                    next_s.rsp.fault = 1'b0;
                end
                OP_REG_READ: begin
                    if (priv && hit) begin
                        next_s.rsp.data = rd;
                    end else begin
                        next_s.rsp.fault = 1'b1;
                    end
                end
                OP_REG_WRITE: begin
                    next_s.rsp.fault = !(priv && hit);
                    if (priv && hit) begin
                        case (req_in.addr)
                            ADDR_SYSTEM_CONFIGURATION: next_s.system_configuration = req_in.wdata[31:0] & SYSTEM_CONFIGURATION_RW_MASK;
                            ADDR_FIX: begin
                                // Attribute bits stay frozen while modify enable is clear
                                if (s.system_configuration[SC_FDM]) begin
                                    next_s.fix = req_in.wdata;
                                end else begin
                                    next_s.fix = (req_in.wdata & ~FIX_ATTR_MASK) | (s.fix & FIX_ATTR_MASK);
                                end
                            end
                            ADDR_DEFTYPE: next_s.deftype = req_in.wdata & DEF_TYPE_MASK;
                            ADDR_TOPMEM: next_s.topmem = req_in.wdata;
                            ADDR_TOPMEM2: next_s.topmem2 = req_in.wdata;
                            ADDR_LEG_TGT: next_s.leg_tgt = req_in.wdata;
                            ADDR_LONG_TGT: next_s.long_tgt = req_in.wdata;
                            ADDR_CMP_TGT: next_s.cmp_tgt = req_in.wdata;
                            ADDR_FMASK: next_s.fmask = req_in.wdata;
                            ADDR_FS_BASE: next_s.fs_base = req_in.wdata;
                            ADDR_GS_BASE: next_s.gs_base = req_in.wdata;
                            ADDR_KGS_BASE: next_s.kgs_base = req_in.wdata;
                            ADDR_FE_CS: next_s.fe_cs = req_in.wdata;
                            ADDR_FE_SP: next_s.fe_sp = req_in.wdata;
                            ADDR_FE_IP: next_s.fe_ip = req_in.wdata;
                            ADDR_DBGCTL: next_s.dbgctl = req_in.wdata;
                            ADDR_CYCLES: next_s.cycles = req_in.wdata;
                            default: begin
                                // Recording registers are read-only; writes there are dropped
                                if (req_in.addr[31:4] == ADDR_VAR[31:4]) begin
                                    if (req_in.addr[0]) begin
                                        next_s.vmask[vidx] = req_in.wdata;
                                    end else begin
                                        next_s.vbase[vidx] = req_in.wdata;
                                    end
                                end else if (req_in.addr[31:3] == ADDR_EVTSEL[31:3]) begin
                                    next_s.evtsel[pidx] = req_in.wdata[31:0];
                                end else if (req_in.addr[31:3] == ADDR_PERFCTR[31:3]) begin
                                    next_s.perfctr[pidx] = req_in.wdata[PERF_W-1:0];
                                end
                            end
                        endcase
                    end
                end
                OP_CNT_READ, OP_CNT_READ_ORD: begin
                    if (priv || !mode_in.counter_read_disable) begin
                        next_s.rsp.data = s.cycles;
                    end else begin
                        next_s.rsp.fault = 1'b1;
                    end
                end
                OP_PERF_READ: begin
                    if ((priv || mode_in.perf_read_enable) && req_in.addr[31:2] == 30'h0000_0000) begin
                        next_s.rsp.data = {16'h0000, s.perfctr[pidx]};
                    end else begin
                        next_s.rsp.fault = 1'b1;
                    end
                end
                OP_BASE_SWAP: begin
                    if (priv) begin
                        next_s.gs_base = s.kgs_base;
                        next_s.kgs_base = s.gs_base;
                    end else begin
                        next_s.rsp.fault = 1'b1;
                    end
                end
                default: begin
                    next_s.rsp.fault = 1'b1;
                end
            endcase
        end

        // ------------------------------------------------------------
        // Linkage outputs
        // ------------------------------------------------------------
        next_s.link.syscall_target = mode_in.mode64 ? s.long_tgt :
            (mode_in.long_active ? s.cmp_tgt : s.leg_tgt);
        next_s.link.syscall_flag_mask = mode_in.long_active ? s.fmask : 64'h0000_0000_0000_0000;
        next_s.link.fs_base = mode_in.mode64 ? s.fs_base : 64'h0000_0000_0000_0000;
        next_s.link.gs_base = mode_in.mode64 ? s.gs_base : 64'h0000_0000_0000_0000;
        next_s.link.fast_entry_allowed = !mode_in.long_active;
        next_s.link.fast_entry_code_selector = s.fe_cs;
        next_s.link.fast_entry_stack_pointer = s.fe_sp;
        next_s.link.fast_entry_instr_pointer = s.fe_ip;

        // ------------------------------------------------------------
        // Memory type lookup
        // ------------------------------------------------------------
        next_s.mem.mem_type = MT_UC;
        next_s.mem.read_to_dram_attr = 1'b0;
        next_s.mem.write_to_dram_attr = 1'b0;
        next_s.mem.variable_range_io_enable = s.system_configuration[SC_VARIABLE_IO_ENABLE_BIT];
        if (s.deftype[DEF_EN]) begin
            next_s.mem.mem_type = s.deftype[2:0];
            if (s.system_configuration[SC_FWB] && s.system_configuration[SC_TOM2EN] && a >= FOUR_GB && a < s.topmem2[PA_W-1:0]) begin
                next_s.mem.mem_type = MT_WB;
            end
            // Lowest index wins on overlap; ranges override forced write-back
            for (int i = VAR_N - 1; i >= 0; i--) begin
                if (s.vmask[i][VAR_VALID] &&
                    ((a[PA_W-1:12] ^ s.vbase[i][PA_W-1:12]) & s.vmask[i][PA_W-1:12]) == 28'h000_0000) begin
                    next_s.mem.mem_type = s.vbase[i][2:0];
                end
            end
            if (s.deftype[DEF_FIX_EN] && a < FIX_LIMIT) begin
                fbyte = s.fix[{a[18:16], 3'b000} +: 8];
                next_s.mem.mem_type = fbyte[2:0];
                next_s.mem.read_to_dram_attr = fbyte[4] & s.system_configuration[SC_FDE];
                next_s.mem.write_to_dram_attr = fbyte[3] & s.system_configuration[SC_FDE];
            end
        end
        next_s.mem.is_dram = 1'b1;
        if (a < FOUR_GB) begin
            if (s.system_configuration[SC_VARIABLE_IO_ENABLE_BIT]) begin
                next_s.mem.is_dram = a < s.topmem[PA_W-1:0];
            end
        end else if (s.system_configuration[SC_TOM2EN]) begin
            next_s.mem.is_dram = a < s.topmem2[PA_W-1:0];
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign rsp_out = s.rsp;
    assign link_out = s.link;
    assign mem_out = s.mem;

endmodule : msb_system_config_bank

`default_nettype wire

// [tb/msb_bank_assertions.sv]
// Purpose: Port checks of the configuration bank.
// Assumes: Every request answered one cycle later.
// Notes:   Register contents are compared by the bench.
`timescale 1ns/10ps
`default_nettype none
module msb_bank_assertions
    import msb_pkg::*;
(
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    input wire msb_req_type req_in,
    input wire msb_mode_type mode_in,
    input wire msb_rsp_type rsp_out,
    input wire msb_link_type link_out
);
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!rst_n_in);
    sequence priv_rd(logic [31:0] a);
        req_in.valid && req_in.op == OP_REG_READ && req_in.cpl == 2'h0 && req_in.addr == a;
    endsequence
    sequence unpriv(msb_op_type o);
        req_in.valid && req_in.op == o && req_in.cpl != 2'h0;
    endsequence
    chk_rsp_follows: assert property (req_in.valid |=> rsp_out.valid)
        else $error("request not answered");
    chk_no_spurious: assert property (!req_in.valid |=> !rsp_out.valid)
        else $error("answer without request");
    chk_unpriv_fault: assert property (unpriv(OP_REG_READ) or unpriv(OP_REG_WRITE)
        |=> rsp_out.fault && rsp_out.data == 64'h0) else $error("unprivileged access allowed");
    chk_cfg_mapped: assert property (priv_rd(ADDR_SYSTEM_CONFIGURATION)
        |=> !rsp_out.fault && (rsp_out.data & ~{32'h0, SYSTEM_CONFIGURATION_RW_MASK}) == 64'h0)
        else $error("configuration read wrong");
    chk_cycle_step: assert property (priv_rd(ADDR_CYCLES) ##1 priv_rd(ADDR_CYCLES)
        |=> rsp_out.data == $past(rsp_out.data) + 64'h1) else $error("cycle counter step wrong");
    chk_tsc_gate: assert property (unpriv(OP_CNT_READ) or unpriv(OP_CNT_READ_ORD)
        |=> rsp_out.fault == $past(mode_in.counter_read_disable)) else $error("counter gate wrong");
    chk_pmc_gate: assert property (unpriv(OP_PERF_READ) and req_in.addr < 32'h4
        |=> rsp_out.fault == !$past(mode_in.perf_read_enable)) else $error("perf gate wrong");
    chk_flag_mask: assert property (!mode_in.long_active |=> link_out.syscall_flag_mask == 64'h0)
        else $error("flag mask outside long mode");
    chk_seg_base: assert property (!mode_in.mode64 |=> link_out.fs_base == 64'h0 && link_out.gs_base == 64'h0)
        else $error("segment base outside 64-bit mode");
    chk_fast_entry: assert property (mode_in.long_active |=> !link_out.fast_entry_allowed)
        else $error("fast entry in long mode");
endmodule : msb_bank_assertions
bind msb_system_config_bank msb_bank_assertions msb_bank_assertions_i (.core_clk_in(core_clk_in),
    .rst_n_in(rst_n_in), .req_in(req_in), .mode_in(mode_in), .rsp_out(rsp_out), .link_out(link_out));
`default_nettype wire

// [tb/msb_sw_model.sv]
// Purpose: Software at a given privilege level issuing register instructions.
// Assumes: One or two back-to-back requests per call.
// Notes:   Released requests show inverted address and write data; privilege level is kept.
`timescale 1ns/10ps
`default_nettype none
module msb_sw_model
    import msb_pkg::*;
(
    input wire logic core_clk_in,
    input wire msb_rsp_type rsp_in,
    output var msb_req_type req_out
);
    logic [63:0] rdata [2];
    logic [1:0] rstat [2];
    initial req_out = '0;
    task automatic op(input msb_op_type o, input logic [1:0] c, input logic [31:0] a,
                      input logic [63:0] d, input int n);
        @(posedge core_clk_in);
        req_out <= '{1'b1, o, c, a, d};
        // Answer stands for one cycle after the taking edge; read it once settled
        for (int i = 0; i < n; i++) begin
            @(posedge core_clk_in);
            #1;
            if (i == n - 1) begin
                req_out <= '{1'b0, OP_NONE, c, ~a, ~d};
            end
            rdata[i] = rsp_in.data;
            rstat[i] = {rsp_in.valid, rsp_in.fault};
        end
    endtask : op
endmodule : msb_sw_model
`default_nettype wire

// [tb/msb_system_config_bank_test.sv]
// Purpose: Self-checking bench of the configuration bank.
// Assumes: Table rows run in order on shared state.
// Notes:   Branch and event lines held low except in the recording and counter tests.
`timescale 1ns/10ps
`default_nettype none
module msb_system_config_bank_test
    import msb_pkg::*;
;
    typedef struct packed {
        msb_op_type op; logic [1:0] cpl; logic [31:0] a; logic [63:0] wd; logic [63:0] rd; logic flt;
    } msb_row_type;
    typedef struct packed {
        logic [31:0] cfg; logic [11:0] dt; logic [PA_W-1:0] a; logic [4:0] exp;
    } msb_mrow_type;
    localparam msb_row_type ROWS [19] = '{
        '{OP_REG_WRITE, 2'h0, ADDR_SYSTEM_CONFIGURATION, 64'hFFFF_FFFF_FFFF_FFFF, 64'h0, 1'b0},
        '{OP_REG_READ, 2'h0, ADDR_SYSTEM_CONFIGURATION, 64'h0, 64'h007C_0000, 1'b0},
        '{OP_REG_WRITE, 2'h3, ADDR_SYSTEM_CONFIGURATION, 64'h0, 64'h0, 1'b1},
        '{OP_REG_READ, 2'h3, ADDR_SYSTEM_CONFIGURATION, 64'h0, 64'h0, 1'b1},
        '{OP_REG_READ, 2'h0, ADDR_SYSTEM_CONFIGURATION, 64'h0, 64'h007C_0000, 1'b0},
        '{OP_REG_WRITE, 2'h0, ADDR_FIX, FIX_ATTR_MASK, 64'h0, 1'b0},
        '{OP_REG_READ, 2'h0, ADDR_FIX, 64'h0, FIX_ATTR_MASK, 1'b0},
        '{OP_REG_WRITE, 2'h0, ADDR_SYSTEM_CONFIGURATION, 64'h0, 64'h0, 1'b0},
        '{OP_REG_READ, 2'h0, ADDR_FIX, 64'h0, 64'h0, 1'b0},
        '{OP_REG_WRITE, 2'h0, ADDR_FIX, 64'h0, 64'h0, 1'b0},
        '{OP_REG_WRITE, 2'h0, ADDR_SYSTEM_CONFIGURATION, 64'h0008_0000, 64'h0, 1'b0},
        '{OP_REG_READ, 2'h0, ADDR_FIX, 64'h0, FIX_ATTR_MASK, 1'b0},
        '{OP_REG_WRITE, 2'h0, ADDR_GS_BASE, 64'h1111, 64'h0, 1'b0},
        '{OP_REG_WRITE, 2'h0, ADDR_KGS_BASE, 64'h2222, 64'h0, 1'b0},
        '{OP_BASE_SWAP, 2'h0, 32'h0, 64'h0, 64'h0, 1'b0},
        '{OP_REG_READ, 2'h0, ADDR_GS_BASE, 64'h0, 64'h2222, 1'b0},
        '{OP_REG_READ, 2'h0, 32'h4000_00FF, 64'h0, 64'h0, 1'b1},
        '{OP_CNT_READ, 2'h3, 32'h0, 64'h0, 64'h0, 1'b0},
        '{OP_PERF_READ, 2'h3, 32'h0, 64'h0, 64'h0, 1'b1}};
    localparam msb_mrow_type MROWS [5] = '{
        '{32'h0060_0000, 12'h800, FOUR_GB, {MT_WB, 2'b10}},
        '{32'h0020_0000, 12'h800, FOUR_GB, {MT_UC, 2'b10}},
        '{32'h0060_0000, 12'h000, FOUR_GB, {MT_UC, 2'b10}},
        '{32'h0060_0000, 12'h805, 40'h00_0010_0000, {3'h5, 2'b10}},
        '{32'h0010_0000, 12'h806, 40'h00_0010_0000, {MT_WB, 2'b01}}};
    logic core_clk_in;
    logic rst_n_in;
    msb_req_type req;
    msb_rsp_type rsp;
    msb_mode_type mode;
    msb_link_type link;
    msb_mem_type mem;
    logic [PA_W-1:0] maddr;
    msb_branch_type br;
    logic [7:0] pev;
    int error_cnt = 0;
    int n_checks = 0;
    msb_system_config_bank msb_system_config_bank_i (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
        .req_in(req), .mode_in(mode), .branch_in(br), .perf_events_in(pev), .mem_addr_in(maddr),
        .rsp_out(rsp), .link_out(link), .mem_out(mem));
    msb_sw_model msb_sw_model_i (.core_clk_in(core_clk_in), .rsp_in(rsp), .req_out(req));
    // ----------
    // Helpers
    // ----------
    task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string msg);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t %s: saw %h expected %h", $time, msg, seen, exp);
        end
    endtask : check
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : print_verdict
    initial begin
        core_clk_in = 1'b0;
        forever #4 core_clk_in = ~core_clk_in;
    end
    initial begin
        repeat (5000) @(posedge core_clk_in);
        error_cnt++;
        $display("[FAIL] %0t watchdog expired", $time);
        print_verdict();
    end
    // ----------
    // Tests
    // ----------
    initial begin
        rst_n_in = 1'b0;
        mode = '0;
        maddr = '0;
        br = '0;
        pev = 8'h00;
        repeat (8) @(posedge core_clk_in);
        rst_n_in <= 1'b1;
        foreach (ROWS[i]) begin
            msb_sw_model_i.op(ROWS[i].op, ROWS[i].cpl, ROWS[i].a, ROWS[i].wd, 1);
            check(64'({msb_sw_model_i.rstat[0]}), {62'h0, 1'b1, ROWS[i].flt}, "row status");
            if (ROWS[i].op inside {OP_REG_READ, OP_PERF_READ}) begin
                check(msb_sw_model_i.rdata[0], ROWS[i].rd, "row data");
            end
        end
        msb_sw_model_i.op(OP_REG_READ, 2'h0, ADDR_CYCLES, 64'h0, 2);
        check(msb_sw_model_i.rdata[1], msb_sw_model_i.rdata[0] + 64'h1, "cycle step");
        $display("table tests done");
        msb_sw_model_i.op(OP_REG_WRITE, 2'h0, ADDR_TOPMEM2, 64'h0000_0002_0000_0000, 1);
        foreach (MROWS[i]) begin
            maddr <= MROWS[i].a;
            msb_sw_model_i.op(OP_REG_WRITE, 2'h0, ADDR_DEFTYPE, 64'(MROWS[i].dt), 1);
            msb_sw_model_i.op(OP_REG_WRITE, 2'h0, ADDR_SYSTEM_CONFIGURATION, 64'(MROWS[i].cfg), 1);
            repeat (2) @(posedge core_clk_in);
            #1;
            check(64'({mem.mem_type, mem.is_dram, mem.variable_range_io_enable}), 64'(MROWS[i].exp),
                  "memory type");
        end
        $display("memory typing done");
        for (int k = 0; k < 3; k++) begin
            msb_sw_model_i.op(OP_REG_WRITE, 2'h0, ADDR_LEG_TGT + 32'(k), 64'h10 + 64'(k), 1);
        end
        for (int k = 0; k < 3; k++) begin
            mode <= '{k != 0, k == 1, 1'b0, 1'b0};
            repeat (2) @(posedge core_clk_in);
            #1;
            check(link.syscall_target, 64'h10 + 64'(k), "syscall target");
        end
        $display("linkage done");
        msb_sw_model_i.op(OP_REG_WRITE, 2'h0, ADDR_DBGCTL, 64'h1, 1);
        br <= '{1'b1, 64'hA, 64'hB, 1'b0, 64'h0, 64'h0};
        @(posedge core_clk_in);
        #1;
        br <= '0;
        msb_sw_model_i.op(OP_REG_READ, 2'h0, ADDR_LB_SRC, 64'h0, 1);
        check(msb_sw_model_i.rdata[0], 64'hA, "branch source");
        msb_sw_model_i.op(OP_REG_READ, 2'h0, ADDR_LB_DST, 64'h0, 1);
        check(msb_sw_model_i.rdata[0], 64'hB, "branch target");
        msb_sw_model_i.op(OP_REG_WRITE, 2'h0, ADDR_EVTSEL, 64'h0040_0003, 1);
        msb_sw_model_i.op(OP_REG_WRITE, 2'h0, ADDR_PERFCTR, 64'h0, 1);
        pev <= 8'h08;
        repeat (4) @(posedge core_clk_in);
        #1;
        pev <= 8'h00;
        msb_sw_model_i.op(OP_REG_READ, 2'h0, ADDR_PERFCTR, 64'h0, 1);
        check(msb_sw_model_i.rdata[0], 64'h4, "event count");
        $display("recording and counters done");
        mode <= '0;
        rst_n_in <= 1'b0;
        repeat (2) @(posedge core_clk_in);
        check({rsp.valid, link.syscall_target[62:0]}, 64'h0, "outputs in reset");
        rst_n_in <= 1'b1;
        msb_sw_model_i.op(OP_REG_READ, 2'h0, ADDR_SYSTEM_CONFIGURATION, 64'h0, 1);
        check(msb_sw_model_i.rdata[0], 64'h0, "config after reset");
        $display("reset test done");
        print_verdict();
    end
endmodule : msb_system_config_bank_test
`default_nettype wire
